// ---- logic/fer_recorder.sv ----
// Fault event recorder: record building, record store and APB register slave
`timescale 1ns/1ps
// Summary of operation
// (RULE1) A rising edge of combined pickup opens a new fault record.
// (RULE2) Combined pickup is OR of module pickups; combined trip is OR of trips.
// (RULE3) First module pickup seen while idle starts the recorder.
// (RULE4) Measurements are captured into the record when trip is decided.
// (RULE5) A nonzero capture delay postpones that capture after the trip.
// (RULE6) Alarms-and-trips mode stores records even without any trip.
// (RULE7) Trips-only mode discards a fault that ended without trip.
// (RULE8) Notification rises when combined pickup falls.
// (RULE9) Time to trip spans first pickup to first trip.
// (RULE10) Time to trip is unavailable if pickup and trip modules differ.
// (RULE11) Fault duration spans rising to falling edge of combined pickup.
// (RULE12) Store holds 20 records; when full the oldest is replaced.
// (RULE13) Newest record sits in a retained copy; older ones are volatile.
// (RULE14) Fault number counter increments per pickup and is stored.
// (RULE15) Grid fault counter increments per pickup except during reclosing.
// (RULE16) Record names the first pickup module and the first trip module.
// (RULE17) Record carries a tripped flag for the overview.
// (RULE18) Record holds timestamp, parameter set and active adaptive set.
// (RULE19) Notification shows newest record; confirm key dismisses it.
// (RULE20) Settings are not stored; a generation tag flags changed settings.
// (RULE21) Durations count a common free-running tick and saturate.
module fer_recorder #(
  parameter int N_MOD = 8,
  parameter int DEPTH = 20
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Protection modules and system
  input  wire logic [N_MOD-1:0]  mod_pickup,
  input  wire logic [N_MOD-1:0]  mod_trip,
  input  wire logic              tick,
  input  wire logic [31:0]       time_stamp,
  input  wire logic [31:0]       meas_value,
  input  wire logic [3:0]        param_set,
  input  wire logic              adapt_used,
  input  wire logic [3:0]        active_adaptive_set,
  input  wire logic              auto_reclose,
  input  wire logic              confirm_key,
  input  wire logic              settings_changed,
  // Notification, retained record, combined pickup and trip
  output logic                   notify,
  output logic [4:0]             notify_idx,
  output fer_pkg::fer_rec_t      retained_rec,
  output logic                   gen_pickup,
  output logic                   gen_trip
);

  // Refuse sizes that the 5-bit pointers and 8-bit module index cannot hold
  if (N_MOD < 1 || N_MOD > 255 || DEPTH < 1 || DEPTH > 31) begin : g_size_check
    $error("fer_recorder: unsupported parameters");
  end

  // ****************************************
  // Fault state machine
  // ****************************************
  typedef enum logic [1:0] {
    FER_IDLE  = 2'b00,
    FER_FAULT = 2'b01
  } fer_state_t;
  fer_state_t           state;
  logic                 pick_d;
  logic                 rise;
  logic                 fall;
  logic                 trip_seen;
  logic                 first_trip_now;
  logic [31:0]          ctrl;
  logic [15:0]          fault_no;
  logic [15:0]          grid_no;
  logic [15:0]          set_gen;
  logic [15:0]          dly_cnt;
  logic                 meas_pend;
  logic                 meas_done;
  logic [31:0]          meas_hold;
  logic [31:0]          dur_cnt;
  logic [31:0]          ttt_cnt;
  fer_pkg::fer_rec_t    cur;
  fer_pkg::fer_rec_t    mem [DEPTH];
  logic [4:0]           wr_ptr;
  logic [4:0]           count;
  logic [4:0]           rd_sel;
  logic                 store_en;
  fer_pkg::fer_rec_t    next_rec;
  // Lowest set bit index, used for first pickup and first trip
  function automatic logic [7:0] first_set(input logic [N_MOD-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = N_MOD - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 8'(i);
      end
    end
    return r;
  endfunction
  // Combined pickup and trip
  assign gen_pickup     = |mod_pickup; // [RULE2]
  assign gen_trip       = |mod_trip; // [RULE2]
  assign rise           = gen_pickup && !pick_d && state == FER_IDLE; // [RULE1] [RULE3]
  assign fall           = !gen_pickup && pick_d && state == FER_FAULT;
  assign first_trip_now = gen_trip && !trip_seen && state == FER_FAULT;
  // Store decision by recording mode
  always_comb begin
    store_en = 1'b0;
    if (fall) begin
      if (ctrl[fer_pkg::CTRL_MODE_BIT] == fer_pkg::FER_MODE_ALARMS) begin
        store_en = 1'b1; // [RULE6]
      end else begin
        store_en = trip_seen || first_trip_now; // [RULE7]
      end
    end
  end
  // Pickup edge register and state
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pick_d <= 1'b0;
      state  <= FER_IDLE;
    end else begin
      pick_d <= gen_pickup;
      case (state)
        FER_IDLE: begin
          if (rise) begin
            state <= FER_FAULT;
          end
        end
        FER_FAULT: begin
          if (fall) begin
            state <= FER_IDLE;
          end
        end
        default: begin
          state <= FER_IDLE;
        end
      endcase
    end
  end
  // Fault and grid fault counters
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_no <= 16'h0000;
      grid_no  <= 16'h0000;
    end else if (rise) begin
      fault_no <= fault_no + 16'h0001; // [RULE14]
      if (!auto_reclose) begin
        grid_no <= grid_no + 16'h0001; // [RULE15]
      end
    end
  end
  // Tick counters, saturating
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dur_cnt <= 32'h0000_0000;
      ttt_cnt <= 32'h0000_0000;
    end else if (rise) begin
      dur_cnt <= 32'h0000_0000;
      ttt_cnt <= 32'h0000_0000;
    end else if (state == FER_FAULT && tick) begin
      if (dur_cnt != fer_pkg::DUR_MAX) begin
        dur_cnt <= dur_cnt + 32'h0000_0001; // [RULE11] [RULE21]
      end
      if (!trip_seen && ttt_cnt != fer_pkg::DUR_MAX) begin
        ttt_cnt <= ttt_cnt + 32'h0000_0001; // [RULE9] [RULE21]
      end
    end
  end
  // Record header fields at fault start and first trip
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur       <= '0;
      trip_seen <= 1'b0;
    end else if (rise) begin
      trip_seen               <= 1'b0;
      cur                     <= '0;
      cur.stamp               <= time_stamp; // [RULE18]
      cur.param_set           <= param_set; // [RULE18]
      cur.adapt_used          <= adapt_used;
      cur.active_adaptive_set <= adapt_used ? active_adaptive_set : 4'h0; // [RULE18]
      cur.fault_no            <= fault_no + 16'h0001;
      cur.grid_no             <= auto_reclose ? grid_no : grid_no + 16'h0001;
      cur.first_pick          <= first_set(mod_pickup); // [RULE16]
      cur.set_gen             <= set_gen; // [RULE20]
    end else if (first_trip_now) begin
      trip_seen      <= 1'b1;
      cur.tripped    <= 1'b1; // [RULE17]
      cur.first_trip <= first_set(mod_trip); // [RULE16]
      cur.ttt        <= (first_set(mod_trip) != cur.first_pick) ? fer_pkg::TTT_NONE
                        : ((ttt_cnt > 32'h0000_FFFE) ? 16'hFFFE : ttt_cnt[15:0]); // [RULE10]
    end
  end
  // Measurement capture, optionally delayed after the trip
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meas_pend <= 1'b0;
      meas_done <= 1'b0;
      dly_cnt   <= 16'h0000;
      meas_hold <= 32'h0000_0000;
    end else if (rise) begin
      meas_pend <= 1'b0;
      meas_done <= 1'b0;
      meas_hold <= 32'h0000_0000;
    end else if (first_trip_now) begin
      if (ctrl[fer_pkg::CTRL_DLY_LSB +: fer_pkg::CTRL_DLY_W] == 16'h0000) begin
        meas_hold <= meas_value; // [RULE4]
        meas_done <= 1'b1;
      end else begin
        meas_pend <= 1'b1; // [RULE5]
        dly_cnt   <= ctrl[fer_pkg::CTRL_DLY_LSB +: fer_pkg::CTRL_DLY_W];
      end
    end else if (meas_pend && tick) begin
      if (dly_cnt == 16'h0001) begin
        meas_hold <= meas_value; // [RULE5]
        meas_pend <= 1'b0;
        meas_done <= 1'b1;
      end
      dly_cnt <= dly_cnt - 16'h0001;
    end
  end
  // Complete record as written at fault end
  always_comb begin
    next_rec     = cur;
    next_rec.dur = dur_cnt; // [RULE11]
    next_rec.meas = (meas_pend && !meas_done) ? meas_value : meas_hold;
    if (first_trip_now) begin
      next_rec.tripped    = 1'b1;
      next_rec.first_trip = first_set(mod_trip);
      next_rec.ttt        = (first_set(mod_trip) != cur.first_pick) ? fer_pkg::TTT_NONE
                            : ((ttt_cnt > 32'h0000_FFFE) ? 16'hFFFE : ttt_cnt[15:0]);
      next_rec.meas       = meas_value;
    end
  end

  // ****************************************
  // Record store
  // ****************************************
  // Circular store: newest overwrites oldest when full
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= 5'h00;
      count  <= 5'h00;
    end else if (store_en) begin
      wr_ptr <= (wr_ptr == 5'(DEPTH - 1)) ? 5'h00 : wr_ptr + 5'h01; // [RULE12]
      if (count != 5'(DEPTH)) begin
        count <= count + 5'h01; // [RULE12]
      end
    end
  end
  // Volatile record array
  always_ff @(posedge core_clk) begin
    if (store_en) begin
      mem[wr_ptr] <= next_rec;
    end
  end
  // Retained copy of the newest record
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      retained_rec <= '0;
    end else if (store_en) begin
      retained_rec <= next_rec; // [RULE13]
    end
  end
  // Notification, set on fault end, set wins over confirm
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      notify     <= 1'b0;
      notify_idx <= 5'h00;
    end else if (fall) begin
      notify     <= 1'b1; // [RULE8]
      notify_idx <= store_en ? wr_ptr : notify_idx; // [RULE19]
    end else if (confirm_key) begin
      notify <= 1'b0; // [RULE19]
    end
  end
  // Settings generation tag, bumped on each settings change
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      set_gen <= 16'h0000;
    end else if (settings_changed) begin
      set_gen <= set_gen + 16'h0001; // [RULE20]
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic                 wr_acc;
  logic                 rd_acc;
  logic [4:0]           phys;
  logic                 sel_ok;
  fer_pkg::fer_rec_t    rsel;
  assign pready  = 1'b1;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign sel_ok  = rd_sel < count;
  // Index 0 is the newest record
  assign phys    = (wr_ptr > rd_sel) ? wr_ptr - rd_sel - 5'h01
                   : 5'(DEPTH) + wr_ptr - rd_sel - 5'h01;
  assign rsel    = sel_ok ? mem[phys] : '0;
  // Register writes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl   <= fer_pkg::CTRL_RESET;
      rd_sel <= 5'h00;
    end else if (wr_acc) begin
      if (paddr == fer_pkg::ADDR_CTRL) begin
        ctrl <= pwdata & 32'h00FF_FF01;
      end
      if (paddr == fer_pkg::ADDR_RD_SEL) begin
        rd_sel <= pwdata[4:0];
      end
    end
  end
  // Read data and error answer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      case (paddr)
        fer_pkg::ADDR_CTRL:      prdata <= ctrl;
        fer_pkg::ADDR_STATUS:    prdata <= {16'h0000, 3'b000, notify_idx, 1'b0,
                                            count, state == FER_FAULT, notify};
        fer_pkg::ADDR_RD_SEL:    prdata <= {27'h000_0000, rd_sel};
        fer_pkg::ADDR_REC_TIME:  prdata <= rsel.stamp;
        fer_pkg::ADDR_REC_CNT:   prdata <= {rsel.grid_no, rsel.fault_no};
        fer_pkg::ADDR_REC_MOD:   prdata <= {4'h0, rsel.adapt_used, 2'b00, rsel.tripped,
                                            rsel.active_adaptive_set, rsel.param_set,
                                            rsel.first_trip, rsel.first_pick};
        fer_pkg::ADDR_REC_TTT:   prdata <= {15'h0000, sel_ok && rsel.set_gen != set_gen,
                                            rsel.ttt}; // [RULE20]
        fer_pkg::ADDR_REC_DUR:   prdata <= rsel.dur;
        fer_pkg::ADDR_REC_MEAS:  prdata <= rsel.meas;
        fer_pkg::ADDR_ACK:       prdata <= 32'h0000_0000;
        fer_pkg::ADDR_SET_GEN:   prdata <= {16'h0000, set_gen};
        fer_pkg::ADDR_LAST_MEAS: prdata <= retained_rec.meas;
        default: begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_fault_count_step: assert property (@(posedge core_clk) disable iff (!rst_b)
    rise |=> fault_no == $past(fault_no) + 16'h0001) // [RULE14]
    else $error("fault number did not step on pickup");
  a_grid_skip_ar: assert property (@(posedge core_clk) disable iff (!rst_b)
    rise && auto_reclose |=> grid_no == $past(grid_no)) // [RULE15]
    else $error("grid counter stepped during reclosing");
  a_notify_on_fall: assert property (@(posedge core_clk) disable iff (!rst_b)
    fall |=> notify) // [RULE8]
    else $error("notification missing after pickup fall");
  a_trips_only_drop: assert property (@(posedge core_clk) disable iff (!rst_b)
    fall && !trip_seen && !gen_trip && !ctrl[0] |=> count == $past(count)) // [RULE7]
    else $error("untripped fault stored in trips-only mode");
  a_alarm_mode_store: assert property (@(posedge core_clk) disable iff (!rst_b)
    fall && ctrl[0] && count < 5'(DEPTH) |=> count == $past(count) + 5'h01) // [RULE6]
    else $error("fault not stored in alarms mode");
  a_store_full_cap: assert property (@(posedge core_clk) disable iff (!rst_b)
    count <= 5'(DEPTH)) // [RULE12]
    else $error("store count above depth");
  a_retained_newest: assert property (@(posedge core_clk) disable iff (!rst_b)
    store_en |=> retained_rec.fault_no == fault_no) // [RULE13]
    else $error("retained record is not newest");
  a_ttt_mismatch: assert property (@(posedge core_clk) disable iff (!rst_b)
    first_trip_now && first_set(mod_trip) != cur.first_pick |=> cur.ttt == 16'hFFFF) // [RULE10]
    else $error("time to trip not marked unavailable");
  a_dur_saturate: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == FER_FAULT && $past(state) == FER_FAULT && $past(dur_cnt) == 32'hFFFF_FFFF
    |-> dur_cnt == 32'hFFFF_FFFF) // [RULE21]
    else $error("duration counter wrapped");
  a_pickup_or: assert property (@(posedge core_clk) disable iff (!rst_b)
    gen_pickup == (mod_pickup != '0) && gen_trip == (mod_trip != '0)) // [RULE2]
    else $error("combined signals wrong");
  a_start_on_rise: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == FER_IDLE && gen_pickup && !pick_d |=> state == FER_FAULT) // [RULE1] [RULE3]
    else $error("fault not started on pickup rise");
  a_meas_at_trip: assert property (@(posedge core_clk) disable iff (!rst_b)
    first_trip_now && ctrl[23:8] == 16'h0000 && !rise |=> meas_hold == $past(meas_value)) // [RULE4]
    else $error("measurement not captured at trip");
  a_meas_delayed: assert property (@(posedge core_clk) disable iff (!rst_b)
    first_trip_now && ctrl[23:8] != 16'h0000 |=> meas_pend && !meas_done) // [RULE5]
    else $error("measurement not postponed");

endmodule

// ---- logic/fer_pkg.sv ----
// Package: constants and record layout of the fault event recorder
package fer_pkg;

  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_STATUS    = 12'h004;
  localparam logic [11:0] ADDR_RD_SEL    = 12'h008;
  localparam logic [11:0] ADDR_REC_TIME  = 12'h00C;
  localparam logic [11:0] ADDR_REC_CNT   = 12'h010;
  localparam logic [11:0] ADDR_REC_MOD   = 12'h014;
  localparam logic [11:0] ADDR_REC_TTT   = 12'h018;
  localparam logic [11:0] ADDR_REC_DUR   = 12'h01C;
  localparam logic [11:0] ADDR_REC_MEAS  = 12'h020;
  localparam logic [11:0] ADDR_ACK       = 12'h024;
  localparam logic [11:0] ADDR_SET_GEN   = 12'h028;
  localparam logic [11:0] ADDR_LAST_MEAS = 12'h02C;

  // ****************************************
  // Control fields and reset values
  // ****************************************
  localparam int CTRL_MODE_BIT   = 0;
  localparam int CTRL_DLY_LSB    = 8;
  localparam int CTRL_DLY_W      = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] TTT_NONE   = 16'hFFFF;
  localparam logic [31:0] DUR_MAX    = 32'hFFFF_FFFF;

  // Recording modes
  typedef enum logic {
    FER_MODE_TRIPS_ONLY = 1'b0,
    FER_MODE_ALARMS     = 1'b1
  } fer_mode_t;

  // One stored fault record
  typedef struct packed {
    logic [31:0] stamp;
    logic [15:0] fault_no;
    logic [15:0] grid_no;
    logic [7:0]  first_pick;
    logic [7:0]  first_trip;
    logic        tripped;
    logic [3:0]  param_set;
    logic [3:0]  active_adaptive_set;
    logic        adapt_used;
    logic [15:0] set_gen;
    logic [15:0] ttt;
    logic [31:0] dur;
    logic [31:0] meas;
  } fer_rec_t;

endpackage

// ---- tb/fer_prot_model.sv ----
// Protection module model driving pickup and trip levels
`timescale 1ns/1ps
module fer_prot_model #(
  parameter int N_MOD = 8
) (
  // Clock
  input  wire logic             core_clk,
  // Module levels towards the recorder
  output logic      [N_MOD-1:0] mod_pickup,
  output logic      [N_MOD-1:0] mod_trip
);
  // ****************************************
  // Idle levels at time zero
  // ****************************************
  initial begin
    mod_pickup = '0;
    mod_trip   = '0;
  end

  // ****************************************
  // Module actions, each launched after an edge
  // ****************************************
  // One module starts picking up and holds it
  task automatic pick(input int i);
    @(posedge core_clk);
    mod_pickup[i] <= 1'b1;
  endtask

  // One module issues its trip decision
  task automatic trip(input int i);
    @(posedge core_clk);
    mod_trip[i] <= 1'b1;
  endtask

  // All modules drop out together, ending the fault
  task automatic clear();
    @(posedge core_clk);
    mod_pickup <= '0;
    mod_trip   <= '0;
  endtask
endmodule

// ---- tb/fer_recorder_tb.sv ----
// Testbench of the fault event recorder with a protection module model
`timescale 1ns/1ps
module fer_recorder_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic              core_clk, rst_b, psel, penable, pwrite, tick;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, time_stamp, meas_value, meas_a, meas_b;
  logic              pready, pslverr, adapt_used, auto_reclose, confirm_key;
  logic              settings_changed, notify, gen_pickup, gen_trip;
  logic [3:0]        param_set, active_adaptive_set;
  logic [4:0]        notify_idx;
  logic [7:0]        mod_pickup, mod_trip;
  fer_pkg::fer_rec_t retained_rec;
  logic [32:0]       exp_q[$];
  int                err_count, tests_run, cyc, seed;

  // ****************************************
  // Design and far side
  // ****************************************
  fer_recorder #(.N_MOD(8), .DEPTH(20)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mod_pickup(mod_pickup),
    .mod_trip(mod_trip), .tick(tick), .time_stamp(time_stamp),
    .meas_value(meas_value), .param_set(param_set), .adapt_used(adapt_used),
    .active_adaptive_set(active_adaptive_set), .auto_reclose(auto_reclose),
    .confirm_key(confirm_key), .settings_changed(settings_changed),
    .notify(notify), .notify_idx(notify_idx), .retained_rec(retained_rec),
    .gen_pickup(gen_pickup), .gen_trip(gen_trip));

  fer_prot_model #(.N_MOD(8)) u_prot (
    .core_clk(core_clk), .mod_pickup(mod_pickup), .mod_trip(mod_trip));

  // Clock of 8 ns
  always #4 core_clk = ~core_clk;

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Counts: %0d mismatches in %0d comparisons", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Read results against the oldest note, error flag on top
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) begin
        check({pslverr, prdata}, 33'h1_FFFF_FFFF);
      end else begin
        check({pslverr, prdata}, exp_q.pop_front());
      end
    end
  end

  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  // ****************************************
  // Bus cycles and stimulus helpers
  // ****************************************
  task automatic gap(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read with expected data and error flag noted first
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // Spaced timebase pulses, never on a pickup or trip edge
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge core_clk);
      tick <= 1'b1;
      @(posedge core_clk);
      tick <= 1'b0;
      gap(2);
    end
  endtask

  // One-cycle pulse: settings change when set_chg is high, confirm key otherwise
  task automatic pulse(input bit set_chg);
    @(posedge core_clk);
    if (set_chg) settings_changed <= 1'b1;
    else confirm_key <= 1'b1;
    @(posedge core_clk);
    settings_changed <= 1'b0;
    confirm_key      <= 1'b0;
    gap(3);
  endtask

  // One fault: pickup, t1 ticks, optional trip, t2 ticks, drop-out
  task automatic fault(input int pk, input int tr, input int t1, input int t2);
    u_prot.pick(pk);
    gap(3);
    check(gen_pickup, 33'h0_0000_0001);
    if (pk > 0) u_prot.pick(0);
    ticks(t1);
    meas_a = $random(seed);
    meas_value <= meas_a;
    if (tr >= 0) begin
      u_prot.trip(tr);
      gap(3);
      check(gen_trip, 33'h0_0000_0001);
    end
    meas_b = $random(seed);
    meas_value <= meas_b;
    gap(2);
    ticks(t2);
    gap(2);
    meas_value <= $random(seed);
    u_prot.clear();
    gap(4);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    core_clk = 0; rst_b = 0; psel = 0; penable = 0; pwrite = 0; tick = 0;
    paddr = 12'h000; pwdata = 32'h0000_0000; meas_value = 32'h0000_0000;
    time_stamp = 32'h0000_0000; param_set = 4'h0; adapt_used = 0;
    active_adaptive_set = 4'h0; auto_reclose = 0; confirm_key = 0;
    settings_changed = 0; err_count = 0; tests_run = 0; cyc = 0; seed = 34;
    gap(20);
    rst_b <= 1'b1;
    gap(2);
    rd(fer_pkg::ADDR_CTRL, fer_pkg::CTRL_RESET, 1'b0);
    rd(12'hFFC, 32'h0000_0000, 1'b1);
    // Trips-only fault with trip, measurement at the trip
    time_stamp <= $random(seed);
    param_set  <= 4'h3;
    gap(1);
    fault(3, 3, 5, 4);
    check(notify, 33'h0_0000_0001);
    check(retained_rec.first_pick, 33'h0_0000_0003);
    check(retained_rec.first_trip, 33'h0_0000_0003);
    check(retained_rec.tripped, 33'h0_0000_0001);
    check(retained_rec.stamp, {1'b0, time_stamp});
    check(retained_rec.param_set, 33'h0_0000_0003);
    apb(1'b1, fer_pkg::ADDR_RD_SEL, 32'h0000_0000);
    rd(fer_pkg::ADDR_REC_CNT, 32'h0001_0001, 1'b0);
    rd(fer_pkg::ADDR_REC_TTT, 32'h0000_0005, 1'b0);
    rd(fer_pkg::ADDR_REC_DUR, 32'h0000_0009, 1'b0);
    rd(fer_pkg::ADDR_REC_MEAS, meas_a, 1'b0);
    rd(fer_pkg::ADDR_REC_TIME, time_stamp, 1'b0);
    pulse(1'b1);
    rd(fer_pkg::ADDR_REC_TTT, 32'h0001_0005, 1'b0);
    rd(fer_pkg::ADDR_SET_GEN, 32'h0000_0001, 1'b0);
    pulse(1'b0);
    check(notify, 33'h0_0000_0000);
    // Trips-only fault without trip is dropped
    fault(2, -1, 2, 0);
    check(retained_rec.fault_no, 33'h0_0000_0001);
    pulse(1'b0);
    // Alarms mode, no trip, inside a reclose sequence
    apb(1'b1, fer_pkg::ADDR_CTRL, 32'h0000_0001);
    auto_reclose <= 1'b1;
    fault(6, -1, 3, 0);
    auto_reclose <= 1'b0;
    check(notify, 33'h0_0000_0001);
    check(retained_rec.tripped, 33'h0_0000_0000);
    rd(fer_pkg::ADDR_REC_CNT, 32'h0002_0003, 1'b0);
    // Different modules, delayed capture of two ticks
    apb(1'b1, fer_pkg::ADDR_CTRL, 32'h0000_0201);
    adapt_used          <= 1'b1;
    active_adaptive_set <= 4'h5;
    fault(1, 4, 2, 3);
    check(retained_rec.first_pick, 33'h0_0000_0001);
    check(retained_rec.first_trip, 33'h0_0000_0004);
    check(retained_rec.active_adaptive_set, 33'h0_0000_0005);
    rd(fer_pkg::ADDR_REC_CNT, 32'h0003_0004, 1'b0);
    rd(fer_pkg::ADDR_REC_TTT, {16'h0000, fer_pkg::TTT_NONE}, 1'b0);
    rd(fer_pkg::ADDR_REC_DUR, 32'h0000_0005, 1'b0);
    rd(fer_pkg::ADDR_REC_MEAS, meas_b, 1'b0);
    rd(fer_pkg::ADDR_REC_MOD, 32'h0953_0401, 1'b0);
    rd(fer_pkg::ADDR_LAST_MEAS, meas_b, 1'b0);
    // Twenty more records push the oldest out
    apb(1'b1, fer_pkg::ADDR_CTRL, 32'h0000_0001);
    for (int i = 0; i < 20; i++) begin
      fault($unsigned($random(seed)) % 8, -1, 1, 0);
    end
    rd(fer_pkg::ADDR_REC_CNT, 32'h0017_0018, 1'b0);
    rd(fer_pkg::ADDR_STATUS, 32'h0000_0251, 1'b0);
    apb(1'b1, fer_pkg::ADDR_RD_SEL, 32'h0000_0013);
    rd(fer_pkg::ADDR_REC_CNT, 32'h0004_0005, 1'b0);
    apb(1'b1, fer_pkg::ADDR_RD_SEL, 32'h0000_0014);
    rd(fer_pkg::ADDR_REC_CNT, 32'h0000_0000, 1'b0);
    check(retained_rec.fault_no, 33'h0_0000_0018);
    check(notify_idx, 33'h0_0000_0002);
    gap(4);
    check(exp_q.size(), 33'h0_0000_0000);
    stop_test();
  end
endmodule
